// ==== isolated_input_relay_port.sv ====
/*
  Isolated input / relay output port with filter and change interrupt.
  Assumes the host bus decodes the base and presents one-cycle rd/wr strobes
  with the low three address bits; read data is registered one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module isolated_input_relay_port #(
  parameter int INPUTS = 16,
  parameter int FILTER_CYCLES = relay_port_pkg::FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire relay_port_pkg::io_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [15:0] relay_output_bit,
  input wire logic [INPUTS-1:0] isolated_input_bit,
  output logic irq
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire rd2 = req.rd && req.addr == relay_port_pkg::OFF_IRQ_ENABLE_DISABLE;
  wire rd3 = req.rd && req.addr == relay_port_pkg::OFF_FILTER_ENABLE_DISABLE;
  wire wr0 = req.wr && req.addr == relay_port_pkg::OFF_RELAY_LOW;
  wire wr1 = req.wr && req.addr == relay_port_pkg::OFF_INPUT_LOW_OR_IRQ_CLEAR;
  wire wr2 = req.wr && req.addr == relay_port_pkg::OFF_IRQ_ENABLE_DISABLE;
  wire wr3 = req.wr && req.addr == relay_port_pkg::OFF_FILTER_ENABLE_DISABLE;
  wire wr4 = req.wr && req.addr == relay_port_pkg::OFF_RELAY_HIGH;
  // writes to 5, 6, 7 decode to nothing: accepted, no effect

  logic filter_on;
  logic irq_enable;
  logic irq_pending;
  logic [INPUTS-1:0] level;
  logic [INPUTS-1:0] level_prev;

  // ----------------------------------------------------------------
  // input filters
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < INPUTS; g++)
    begin : g_in
      input_filter #(
        .FILTER_CYCLES(FILTER_CYCLES)
      ) u_filter (
        .clk(clk),
        .rst(rst),
        .pin(isolated_input_bit[g]),
        .filter_on(filter_on),
        .level(level[g])
      );
    end
  endgenerate

  wire [15:0] level16 = 16'(level);
  wire changed = (level != level_prev);

  // ----------------------------------------------------------------
  // relays
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      relay_output_bit <= {relay_port_pkg::RELAY_RESET, relay_port_pkg::RELAY_RESET};
    end
    else
    begin
      if (wr0)
        relay_output_bit[7:0] <= req.wdata;
      if (wr4)
        relay_output_bit[15:8] <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // filter and interrupt control
  // ----------------------------------------------------------------
  // a read and a write never share a cycle, so enable/disable cannot collide
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      filter_on <= 1'b0;
      irq_enable <= 1'b0;
    end
    else
    begin
      if (rd3)
        filter_on <= 1'b1;
      else if (wr3)
        filter_on <= 1'b0;
      if (rd2)
        irq_enable <= 1'b1;
      else if (wr2)
        irq_enable <= 1'b0;
    end
  end

  // pending is sticky; a change in the clear cycle wins over the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level_prev <= '0;
      irq_pending <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      level_prev <= level;
      if (irq_enable && changed)
        irq_pending <= 1'b1;
      else if (wr1)
        irq_pending <= 1'b0;
      irq <= (irq_enable && changed) || (irq_pending && !wr1);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    case (req.addr)
      relay_port_pkg::OFF_RELAY_LOW: next_rdata = relay_output_bit[7:0];
      relay_port_pkg::OFF_RELAY_HIGH: next_rdata = relay_output_bit[15:8];
      relay_port_pkg::OFF_INPUT_LOW_OR_IRQ_CLEAR: next_rdata = level16[7:0];
      relay_port_pkg::OFF_INPUT_HIGH: next_rdata = level16[15:8];
      relay_port_pkg::OFF_IRQ_STATUS:
      begin
        next_rdata[relay_port_pkg::IRQ_ENABLE_BIT0] = irq_enable;
        next_rdata[relay_port_pkg::IRQ_ENABLE_BIT1] = irq_enable;
        next_rdata[relay_port_pkg::IRQ_PENDING_BIT] = irq_pending;
      end
      relay_port_pkg::OFF_FILTER_STATUS:
        next_rdata = filter_on ? relay_port_pkg::FILTER_ON_BYTE
                               : relay_port_pkg::FILTER_OFF_BYTE;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.rd;
      if (req.rd)
        rdata <= next_rdata;
    end
  end

endmodule // isolated_input_relay_port
`default_nettype wire

// ==== relay_port_pkg.sv ====
/*
  Constants and carrier types for the isolated input / relay output port.
  Assumes a host I/O bus that presents byte reads and writes as one-cycle strobes.
*/
// Notes on behaviour
// - Eight byte registers, low three address bits select.
// - All relays off after reset.
// - Writes to 0 and 4 latch relay bytes.
// - Reads of 0 and 4 return relay bytes.
// - Reads of 1 and 5 return input states.
// - Read of 3 enables 5 ms input filter.
// - Any write to 3 disables filter.
// - Read of 7 gives ff or 00.
// - Read of 2 enables interrupts.
// - Any write to 2 disables interrupts.
// - Any write to 1 clears pending interrupt.
// - Read of 6: bits 0,1 enable, bit 2 pending.
// - Enabled: any input edge raises interrupt.
// - Interrupt enable off after reset.
// - Filters off after reset.
package relay_port_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_RELAY_LOW = 3'h0;
  localparam logic [2:0] OFF_INPUT_LOW_OR_IRQ_CLEAR = 3'h1;
  localparam logic [2:0] OFF_IRQ_ENABLE_DISABLE = 3'h2;
  localparam logic [2:0] OFF_FILTER_ENABLE_DISABLE = 3'h3;
  localparam logic [2:0] OFF_RELAY_HIGH = 3'h4;
  localparam logic [2:0] OFF_INPUT_HIGH = 3'h5;
  localparam logic [2:0] OFF_IRQ_STATUS = 3'h6;
  localparam logic [2:0] OFF_FILTER_STATUS = 3'h7;

  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RELAY_RESET = 8'h00;
  localparam logic [7:0] FILTER_ON_BYTE = 8'hff;
  localparam logic [7:0] FILTER_OFF_BYTE = 8'h00;
  localparam int IRQ_ENABLE_BIT0 = 0;
  localparam int IRQ_ENABLE_BIT1 = 1;
  localparam int IRQ_PENDING_BIT = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int FILTER_TIME_MS = 5;
  // longest time, so rounded down
  localparam int FILTER_CYCLES = CLK_HZ / 1000 * FILTER_TIME_MS;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } io_req_s;

endpackage

// ==== input_filter.sv ====
/*
  One isolated input: three-stage synchroniser and a settle filter.
  Assumes the raw pin is asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module input_filter #(
  parameter int FILTER_CYCLES = relay_port_pkg::FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic filter_on,
  output logic level
);

  localparam int CW = $clog2(FILTER_CYCLES + 1);

  logic sync1;
  logic sync2;
  logic sync3;
  logic [CW-1:0] count;

  // a change counts once stages two and three agree
  wire stable = (sync2 == sync3);
  wire differs = stable && (sync3 != level);
  wire settled = (count >= CW'(FILTER_CYCLES - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // with filter_on, filtered level follows only after the input has held for the full time; without it, once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      level <= 1'b0;
    end
    else if (!differs)
    begin
      count <= '0;
    end
    else if (!filter_on || settled)
    begin
      count <= '0;
      level <= sync3;
    end
    else
    begin
      count <= count + CW'(1);
    end
  end

endmodule // input_filter
`default_nettype wire

// ==== port_asserts.sv ====
/* assertion checker for the relay port, bound to its top module
   sees only port signals; the internal enables are mirrored from bus traffic */
`timescale 1ns/100ps
`default_nettype none
module port_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire relay_port_pkg::io_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [15:0] relay_output_bit,
  input wire logic irq
);
  logic filt;
  logic ien;
  wire [2:0] a = req.addr;
  wire [15:0] ro = relay_output_bit;
  wire [7:0] rsel = a[2] ? ro[15:8] : ro[7:0];
  wire wr0 = req.wr && a == 3'h0;
  wire wr4 = req.wr && a == 3'h4;
  wire clr = req.wr && a == 3'h1;
  wire next_filt = (req.rd && a == 3'h3) || (filt && !(req.wr && a == 3'h3));
  wire next_ien = (req.rd && a == 3'h2) || (ien && !(req.wr && a == 3'h2));
  always_ff @(posedge clk or posedge rst)
    if (rst)
      {filt, ien} <= 2'h0;
    else
      {filt, ien} <= {next_filt, next_ien};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  read_answer_a: assert property (req.rd |=> rvalid) else $error("no answer");
  relay_low_a: assert property (wr0 |=> ro == {$past(ro[15:8]), $past(req.wdata)})
    else $error("low relays");
  relay_high_a: assert property (wr4 |=> ro == {$past(req.wdata), $past(ro[7:0])})
    else $error("high relays");
  relay_hold_a: assert property (!wr0 && !wr4 |=> $stable(ro))
    else $error("relays moved");
  relay_read_a: assert property (req.rd && a[1:0] == 2'h0 |=> rdata == $past(rsel))
    else $error("relay readback");
  filter_stat_a: assert property (req.rd && a == 3'h7 |=> rdata == {8{$past(filt)}})
    else $error("filter status");
  irq_stat_a: assert property (req.rd && a == 3'h6 |=> rdata[7:0] ==
    {5'h00, $past(irq), {2{$past(ien)}}}) else $error("irq status");
  irq_hold_a: assert property (irq && !clr |=> irq) else $error("irq dropped");
  irq_gate_a: assert property ($rose(irq) |-> $past(ien)) else $error("irq while off");
  cover property (clr && irq);
  cover property (req.rd && a == 3'h7 && filt);
  cover property ($rose(irq));
endmodule // port_asserts
bind isolated_input_relay_port port_asserts port_asserts_i (.clk(clk), .rst(rst), .req(req),
  .rdata(rdata), .rvalid(rvalid), .relay_output_bit(relay_output_bit), .irq(irq));
`default_nettype wire

// ==== host.sv ====
/* host model: issues byte I/O reads and writes to the port
   assumes read data answers one cycle after the strobe */
`timescale 1ns/100ps
`default_nettype none
module host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output var relay_port_pkg::io_req_s req
);
  initial req = 12'h000;
  // an idle cycle after each request keeps every strobe a single pulse
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req <= {1'h0, 1'h1, a, d};
    @(posedge clk);
    req <= 12'h000;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q, output logic v);
    req <= {1'h1, 1'h0, a, 8'h00};
    @(posedge clk);
    req <= 12'h000;
    @(posedge clk);
    q = rdata;
    v = rvalid;
  endtask
endmodule // host
`default_nettype wire

// ==== tb.sv ====
/* self-checking bench for the relay port
   inputs change at rising edges; the host model runs the bus */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] ins = 16'h0000;
  relay_port_pkg::io_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [15:0] ro;
  logic irq;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  host host_i (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  // short filter so a settle takes a few cycles
  isolated_input_relay_port #(.FILTER_CYCLES(8)) isolated_input_relay_port_i (.clk(clk),
    .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid), .relay_output_bit(ro),
    .isolated_input_bit(ins), .irq(irq));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic v;
    host_i.rd(a, q, v);
    chk({15'h0000, v}, 16'h0001);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic stop_test;
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      stop_test();
    end
  end
  task automatic t_reset;
    chk(ro, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rdc(3'h7, 8'h00);
    rdc(3'h6, 8'h00);
  endtask
  task automatic t_relay;
    host_i.wr(3'h0, 8'h81);
    host_i.wr(3'h4, 8'hc3);
    chk(ro, 16'hc381);
    rdc(3'h0, 8'h81);
    rdc(3'h4, 8'hc3);
    for (int i = 5; i < 8; i++)
      host_i.wr(i[2:0], 8'hff);
    chk(ro, 16'hc381);
    rdc(3'h7, 8'h00);
  endtask
  task automatic t_input;
    ins <= 16'ha53c;
    repeat (10) @(posedge clk);
    rdc(3'h1, 8'h3c);
    rdc(3'h5, 8'ha5);
  endtask
  task automatic t_filter;
    rdc(3'h3, 8'h00);
    rdc(3'h7, 8'hff);
    ins <= 16'ha5c3;
    repeat (5) @(posedge clk);
    rdc(3'h1, 8'h3c);
    repeat (20) @(posedge clk);
    rdc(3'h1, 8'hc3);
    host_i.wr(3'h3, 8'h55);
    rdc(3'h7, 8'h00);
  endtask
  task automatic t_irq;
    ins <= 16'h0000;
    repeat (10) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    rdc(3'h2, 8'h00);
    rdc(3'h6, 8'h03);
    ins <= 16'h8000;
    repeat (10) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    ins <= 16'h0000;
    repeat (10) @(posedge clk);
    rdc(3'h6, 8'h07);
    host_i.wr(3'h1, 8'haa);
    chk({15'h0000, irq}, 16'h0000);
    host_i.wr(3'h2, 8'h00);
    rdc(3'h6, 8'h00);
    ins <= 16'h0001;
    repeat (10) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_relay();
    t_input();
    t_filter();
    t_irq();
    stop_test();
  end
endmodule // tb
`default_nettype wire
